// ---- rtl/mra_pkg.sv ----
// package of the memory region attribute lookup
// assumes one processor clock and a word-wide register port
package mra_pkg;

	// ------------------------------------------------------------
	// register indices on the control register port
	// ------------------------------------------------------------
	localparam logic [2:0] REG_DEFAULT_CFG = 3'h0; // default_region_config
	localparam logic [2:0] REG_T0_BASE     = 3'h1; // template0_base
	localparam logic [2:0] REG_T1_BASE     = 3'h2; // template1_base
	localparam logic [2:0] REG_T0_MASK     = 3'h3; // template0_mask
	localparam logic [2:0] REG_T1_MASK     = 3'h4; // template1_mask

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int FLD_ADDR_LO   = 12; // base_address_field / address_mask_field low bit
	localparam int FLD_ADDR_HI   = 31; // field high bit
	localparam int FLD_BIG_END   = 0;  // big_endian_bit in default and base registers
	localparam int FLD_DCACHE    = 1;  // data cache enable in default and base registers
	localparam int FLD_TMPL_EN   = 0;  // template_enable_bit in mask registers
	localparam int FLD_BOOT_BE   = 31; // big-endian bit of the boot configuration image
	localparam int ADDR_FLD_W    = 20; // width of the compared address field

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [19:0] RST_FIELD = 20'h00000; // base and mask fields
	localparam logic        RST_EN    = 1'b0;      // templates disabled
	localparam logic        RST_DCEN  = 1'b0;      // data caching disabled

	// ------------------------------------------------------------
	// template hit codes
	// ------------------------------------------------------------
	localparam logic [1:0] HIT_NONE = 2'h0;
	localparam logic [1:0] HIT_T0   = 2'h1;
	localparam logic [1:0] HIT_T1   = 2'h2;

	// ------------------------------------------------------------
	// timing: a split access emits at most this many pieces
	// ------------------------------------------------------------
	localparam int MAX_PIECES = 16;

	// lookup sequencer state, one-hot
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b01,
		ST_SPLIT = 2'b10
	} mra_state_t;

	// whole state of the lookup block
	typedef struct packed {
		mra_state_t  st;        // sequencer state
		logic [19:0] base0;     // template 0 base field
		logic [19:0] base1;     // template 1 base field
		logic        bcen0;     // template 0 data cache enable
		logic        bcen1;     // template 1 data cache enable
		logic [19:0] mask0;     // template 0 mask field
		logic [19:0] mask1;     // template 1 mask field
		logic        te0;       // template 0 enable
		logic        te1;       // template 1 enable
		logic        dfltBe;    // default big-endian
		logic        dfltDcen;  // default data cache enable
		logic [31:0] pAddr;     // next piece address while splitting
		logic [4:0]  pRem;      // bytes still to issue while splitting
		logic        pFetch;    // split access is a fetch
		logic        pDram;     // split access targets data RAM
		logic        rspValid;  // attribute answer valid
		logic [31:0] rspAddr;   // piece address
		logic [4:0]  rspLen;    // piece length in bytes
		logic        rspFetch;  // piece is an instruction fetch
		logic        rspCache;  // piece is data cacheable
		logic        rspBe;     // piece is byte reordered
		logic [1:0]  rspHit;    // template that covered the piece
		logic        rspLast;   // last piece of the access
		logic        regRvalid; // register read answer valid
		logic [31:0] regRdata;  // register read data
		logic        dcSync;    // cache sync pulse after template write
	} mra_state_s_t;

endpackage

// ---- rtl/mra_byte_swap.sv ----
// byte order converter between external data and the core
// assumes a data width that is a whole number of bytes
module mra_byte_swap #(
	parameter int WIDTH = 32
) (
	// control
	input  wire logic             swapEn,
	// data
	input  wire logic [WIDTH-1:0] dIn,
	output logic      [WIDTH-1:0] dOut
);

	// ------------------------------------------------------------
	// byte lanes
	// ------------------------------------------------------------
	localparam int NBYTES = WIDTH / 8; // lanes in a word

	logic [WIDTH-1:0] swapped; // lanes in reversed order

	// reverse the lanes, purely combinational so no cycle is added
	genvar gi;
	generate
		for (gi = 0; gi < NBYTES; gi++) begin : g_lane
			assign swapped[gi*8 +: 8] = dIn[(NBYTES-1-gi)*8 +: 8];
		end
	endgenerate

	// pick reversed or straight data
	assign dOut = swapEn ? swapped : dIn;

endmodule

// ---- rtl/mra_lookup.sv ----
// memory region attribute lookup: two masked templates and a default
// assumes the core holds an access stable until accReady and that
// register port and access port share clk_sys
// ------------------------------------------------------------
// ------------------------------------------------------------
module mra_lookup
	import mra_pkg::*;
#(
	parameter int DATA_W = 32
) (
	// clock and reset
	input  wire logic              clk_sys,
	input  wire logic              rst_b,
	// boot and re-initialisation
	input  wire logic [31:0]       bootImage,
	input  wire logic              swReinit,
	// control register port
	input  wire logic [2:0]        regSel,
	input  wire logic              regWr,
	input  wire logic              regRd,
	input  wire logic [31:0]       regWdata,
	output logic                   regReady,
	output logic                   regRvalid,
	output logic [31:0]            regRdata,
	output logic                   dcacheSync,
	// access request from the core
	input  wire logic              accValid,
	input  wire logic [31:0]       accAddr,
	input  wire logic [4:0]        accLen,
	input  wire logic              accFetch,
	input  wire logic              accMmr,
	input  wire logic              accDram,
	output logic                   accReady,
	// attribute answer per piece
	output logic                   rspValid,
	output logic [31:0]            rspAddr,
	output logic [4:0]             rspLen,
	output logic                   rspFetch,
	output logic                   rspCache,
	output logic                   rspBe,
	output logic [1:0]             rspHit,
	output logic                   rspLast,
	// read data path
	input  wire logic [DATA_W-1:0] memRdata,
	output logic [DATA_W-1:0]      coreRdata
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	mra_state_s_t q; // registered state
	mra_state_s_t d; // next state

	logic        accTake;  // access accepted this cycle
	logic        regTake;  // register write accepted this cycle
	logic [31:0] accEnd;   // last byte address of the access
	logic [1:0]  hitStart; // template hits of first byte
	logic [1:0]  hitEnd;   // template hits of last byte
	logic        crossing; // access spans two template outcomes
	logic [4:0]  pSize;    // size of the next split piece

	// ------------------------------------------------------------
	// helper functions
	// ------------------------------------------------------------
	// masked compare of one template against an address field
	function automatic logic tmpl_hit(input logic [19:0] a, input logic [19:0] base,
			input logic [19:0] mask, input logic en);
		tmpl_hit = en && (((a ^ base) & mask) == 20'h00000);
	endfunction

	// largest aligned piece that fits in the remaining bytes
	function automatic logic [4:0] piece_size(input logic [1:0] a, input logic [4:0] rem);
		if (a == 2'h0 && rem >= 5'h04) begin
			piece_size = 5'h04;
		end else if (a[0] == 1'b0 && rem >= 5'h02) begin
			piece_size = 5'h02;
		end else begin
			piece_size = 5'h01;
		end
	endfunction

	// ------------------------------------------------------------
	// lookup of the current request
	// ------------------------------------------------------------
	assign accReady = (q.st == ST_IDLE);
	assign accTake  = accValid && accReady;
	// writes wait until no access is in flight or offered
	assign regReady = (q.st == ST_IDLE) && !accValid;
	assign regTake  = regWr && regReady;
	assign accEnd   = accAddr + {27'h0000000, accLen} - 32'h00000001;
	assign pSize    = piece_size(q.pAddr[1:0], q.pRem);

	assign hitStart = {tmpl_hit(accAddr[FLD_ADDR_HI:FLD_ADDR_LO], q.base1, q.mask1, q.te1),
		tmpl_hit(accAddr[FLD_ADDR_HI:FLD_ADDR_LO], q.base0, q.mask0, q.te0)};
	assign hitEnd   = {tmpl_hit(accEnd[FLD_ADDR_HI:FLD_ADDR_LO], q.base1, q.mask1, q.te1),
		tmpl_hit(accEnd[FLD_ADDR_HI:FLD_ADDR_LO], q.base0, q.mask0, q.te0)};
	// control register accesses never split
	assign crossing = !accMmr && (hitStart != hitEnd);

	// ------------------------------------------------------------
	// next-state logic
	// ------------------------------------------------------------
	always_comb begin
		logic [1:0] h;   // hits of the answered piece
		logic       dr;  // answered piece is data RAM
		h  = 2'h0;
		dr = 1'b0;
		d  = q;
		// one-cycle outputs fall by default
		d.rspValid  = 1'b0;
		d.rspLast   = 1'b0;
		d.regRvalid = 1'b0;
		d.dcSync    = 1'b0;
		// register writes; bit zero of a base write is not stored
		if (regTake) begin
			case (regSel)
				REG_DEFAULT_CFG: begin
					d.dfltBe   = regWdata[FLD_BIG_END];
					d.dfltDcen = regWdata[FLD_DCACHE];
				end
				REG_T0_BASE: begin
					d.base0 = regWdata[FLD_ADDR_HI:FLD_ADDR_LO];
					d.bcen0 = regWdata[FLD_DCACHE];
				end
				REG_T1_BASE: begin
					d.base1 = regWdata[FLD_ADDR_HI:FLD_ADDR_LO];
					d.bcen1 = regWdata[FLD_DCACHE];
				end
				REG_T0_MASK: begin
					d.mask0 = regWdata[FLD_ADDR_HI:FLD_ADDR_LO];
					d.te0   = regWdata[FLD_TMPL_EN];
				end
				REG_T1_MASK: begin
					d.mask1 = regWdata[FLD_ADDR_HI:FLD_ADDR_LO];
					d.te1   = regWdata[FLD_TMPL_EN];
				end
				default: begin
				end
			endcase
			// every mapped write syncs the data cache
			d.dcSync = (regSel <= REG_T1_MASK);
		end
		// register reads, unmapped index reads zero
		if (regRd) begin
			d.regRvalid = 1'b1;
			case (regSel)
				REG_DEFAULT_CFG: d.regRdata = {30'h00000000, q.dfltDcen, q.dfltBe};
				REG_T0_BASE:     d.regRdata = {q.base0, 10'h000, q.bcen0, q.dfltBe};
				REG_T1_BASE:     d.regRdata = {q.base1, 10'h000, q.bcen1, q.dfltBe};
				REG_T0_MASK:     d.regRdata = {q.mask0, 11'h000, q.te0};
				REG_T1_MASK:     d.regRdata = {q.mask1, 11'h000, q.te1};
				default:         d.regRdata = 32'h00000000;
			endcase
		end
		// soft re-initialisation keeps byte order
		if (swReinit) begin
			d.dfltDcen = RST_DCEN;
		end
		// access sequencer
		case (q.st)
			ST_IDLE: begin
				if (accTake && crossing) begin
					// remember the access and issue pieces from the next cycle
					d.st     = ST_SPLIT;
					d.pAddr  = accAddr;
					d.pRem   = accLen;
					d.pFetch = accFetch;
					d.pDram  = accDram;
				end else if (accTake) begin
					d.rspValid = 1'b1;
					d.rspLast  = 1'b1;
					d.rspAddr  = accAddr;
					d.rspLen   = accLen;
					d.rspFetch = accFetch;
					// control registers bypass templates and reordering
					h  = accMmr ? HIT_NONE : hitStart;
					dr = accDram;
					d.rspBe    = !accMmr && q.dfltBe;
				end
			end
			ST_SPLIT: begin
				// one aligned piece per cycle, each with its own template
				d.rspValid = 1'b1;
				d.rspAddr  = q.pAddr;
				d.rspLen   = pSize;
				d.rspFetch = q.pFetch;
				d.rspBe    = q.dfltBe;
				h  = {tmpl_hit(q.pAddr[FLD_ADDR_HI:FLD_ADDR_LO], q.base1, q.mask1, q.te1),
					tmpl_hit(q.pAddr[FLD_ADDR_HI:FLD_ADDR_LO], q.base0, q.mask0, q.te0)};
				dr = q.pDram;
				d.pAddr = q.pAddr + {27'h0000000, pSize};
				d.pRem  = q.pRem - pSize;
				if (q.pRem == pSize) begin
					d.rspLast = 1'b1;
					d.st      = ST_IDLE;
				end
			end
			default: begin
				d.st = ST_IDLE;
			end
		endcase
		// attribute selection for an answered piece
		if (d.rspValid) begin
			// template 0 wins an overlap, which software must not program
			d.rspHit = h[0] ? HIT_T0 : (h[1] ? HIT_T1 : HIT_NONE);
			if (dr) begin
				d.rspCache = 1'b0;
			end else if (h[0]) begin
				d.rspCache = q.bcen0;
			end else if (h[1]) begin
				d.rspCache = q.bcen1;
			end else begin
				// control register pieces reach here with no hit
				d.rspCache = q.dfltDcen;
			end
		end
		// hardware reset
		if (!rst_b) begin
			d          = '0;
			d.st       = ST_IDLE;
			d.base0    = RST_FIELD;
			d.base1    = RST_FIELD;
			d.mask0    = RST_FIELD;
			d.mask1    = RST_FIELD;
			d.te0      = RST_EN;
			d.te1      = RST_EN;
			d.dfltDcen = RST_DCEN;
			d.dfltBe   = bootImage[FLD_BOOT_BE];
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		q <= d;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign regRvalid  = q.regRvalid;
	assign regRdata   = q.regRdata;
	assign dcacheSync = q.dcSync;
	assign rspValid   = q.rspValid;
	assign rspAddr    = q.rspAddr;
	assign rspLen     = q.rspLen;
	assign rspFetch   = q.rspFetch;
	assign rspCache   = q.rspCache;
	assign rspBe      = q.rspBe;
	assign rspHit     = q.rspHit;
	assign rspLast    = q.rspLast;

	// byte order conversion on the returning data
	mra_byte_swap #(
		.WIDTH (DATA_W)
	) u_swap (
		.swapEn (q.rspBe),
		.dIn    (memRdata),
		.dOut   (coreRdata)
	);

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	sequence s_cross_take;
		accTake && crossing;
	endsequence
	sequence s_last_piece;
		rspValid && rspLast;
	endsequence

	a_default_attr: assert property (accTake && !crossing && !accDram && hitStart == 2'h0
		|=> rspCache == $past(q.dfltDcen) && rspHit == HIT_NONE)
		else $error("default attributes not applied");
	a_global_order: assert property (accTake && !accMmr && !crossing
		|=> rspBe == $past(q.dfltBe))
		else $error("byte order not from default register");
	a_tmpl_select: assert property (accTake && !crossing && !accMmr && hitStart == 2'h1
		|=> rspHit == HIT_T0 && (rspCache == ($past(q.bcen0) && !$past(accDram))))
		else $error("template attributes not applied");
	a_swap_zero: assert property (rspValid && rspBe
		|-> coreRdata == {memRdata[7:0], memRdata[15:8], memRdata[23:16], memRdata[31:24]})
		else $error("big-endian data not swapped");
	a_base_readback: assert property (regRd && (regSel == REG_T0_BASE || regSel == REG_T1_BASE)
		|=> regRvalid && regRdata[0] == $past(q.dfltBe))
		else $error("base read misses big-endian bit");
	a_reset_clear: assert property ($past(rst_b) == 1'b0
		|-> !q.te0 && !q.te1 && !q.dfltDcen && q.dfltBe == $past(bootImage[31]))
		else $error("reset values wrong");
	a_reinit_keep: assert property (swReinit && !(regTake && regSel == REG_DEFAULT_CFG)
		|=> !q.dfltDcen && $stable(q.dfltBe))
		else $error("re-initialisation wrong");
	a_mmr_bypass: assert property (accTake && accMmr
		|=> rspValid && rspHit == HIT_NONE && !rspBe)
		else $error("control register access matched");
	a_dram_nocache: assert property (accTake && accDram && !crossing |=> !rspCache)
		else $error("data RAM cached");
	a_split_ends: assert property (s_cross_take |-> ##2 rspValid ##[0:15] s_last_piece)
		else $error("split access did not finish");
	// a write must never land between two pieces of one split access
	a_write_order: assert property (regTake |-> !(rspValid && !rspLast))
		else $error("register write during access");
	// every mapped write is followed by the cache sync pulse
	a_write_sync: assert property (regTake && regSel <= REG_T1_MASK |=> dcacheSync)
		else $error("no cache sync after template write");

endmodule

// ---- verif/mra_core_model.sv ----
// core-side partner: issues loads, stores and fetches to the lookup
// assumes its outputs may change on the falling edge of clk_sys only
module mra_core_model (
	// clock
	input  wire logic        clk_sys,
	// access request
	output logic             accValid,
	output logic [31:0]      accAddr,
	output logic [4:0]       accLen,
	output logic             accFetch,
	output logic             accMmr,
	output logic             accDram,
	input  wire logic        accReady,
	// attribute answer
	input  wire logic        rspValid,
	input  wire logic [31:0] rspAddr,
	input  wire logic [4:0]  rspLen,
	input  wire logic [1:0]  rspHit,
	input  wire logic        rspCache,
	input  wire logic        rspBe,
	input  wire logic        rspLast,
	// read data
	output logic [31:0]      memRdata,
	input  wire logic [31:0] coreRdata
);
	timeunit 1ns;
	timeprecision 1ps;

	// gathered pieces: {addr, len, hit, cache, be, last, core data}
	logic [73:0] pieces[$];

	// ---------------------------------------------
	// idle values
	// ---------------------------------------------
	initial begin
		accValid = 1'b0;
		accAddr  = 32'h0;
		accLen   = 5'h1;
		accFetch = 1'b0;
		accMmr   = 1'b0;
		accDram  = 1'b0;
		memRdata = 32'h11223344; // external word, distinct in every byte
	end

	// one access: request held until taken, then pieces gathered
	task automatic access(input logic [31:0] a, input logic [4:0] n, input logic f,
			input logic m, input logic d);
		int i;
		pieces.delete();
		@(negedge clk_sys);
		accValid = 1'b1;
		accAddr  = a;
		accLen   = n;
		accFetch = f;
		accMmr   = m;
		accDram  = d;
		i = 0;
		// ready is settled on the falling edge, so it holds at the next rising one
		while (accReady !== 1'b1 && i < 50) begin
			@(negedge clk_sys);
			i++;
		end
		@(negedge clk_sys);
		accValid = 1'b0;
		accAddr  = ~a; // released address no longer shows the old value
		for (i = 0; i < 20; i++) begin
			if (rspValid === 1'b1) begin
				pieces.push_back({rspAddr, rspLen, rspHit, rspCache, rspBe, rspLast, coreRdata});
			end
			if (rspLast === 1'b1) begin
				break;
			end
			@(negedge clk_sys);
		end
	endtask
endmodule

// ---- verif/mra_lookup_test.sv ----
// testbench of the memory region attribute lookup
// assumes the core partner model and the design package are compiled first
module mra_lookup_test
	import mra_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ---------------------------------------------
	// signals
	// ---------------------------------------------
	logic        clk_sys, rst_b, swReinit, regWr, regRd, regReady, regRvalid, dcacheSync;
	logic [31:0] bootImage, regWdata, regRdata, accAddr, rspAddr, memRdata, coreRdata;
	logic [2:0]  regSel;
	logic        accValid, accFetch, accMmr, accDram, accReady;
	logic        rspValid, rspFetch, rspCache, rspBe, rspLast;
	logic [4:0]  accLen, rspLen;
	logic [1:0]  rspHit;
	int          n_errors = 0;
	int          total_checks = 0;

	// clock of 40 ns period
	always #20 clk_sys = ~clk_sys;

	mra_lookup #(.DATA_W(32)) i_mra_lookup (
		.clk_sys(clk_sys), .rst_b(rst_b), .bootImage(bootImage), .swReinit(swReinit),
		.regSel(regSel), .regWr(regWr), .regRd(regRd), .regWdata(regWdata),
		.regReady(regReady), .regRvalid(regRvalid), .regRdata(regRdata),
		.dcacheSync(dcacheSync), .accValid(accValid), .accAddr(accAddr), .accLen(accLen),
		.accFetch(accFetch), .accMmr(accMmr), .accDram(accDram), .accReady(accReady),
		.rspValid(rspValid), .rspAddr(rspAddr), .rspLen(rspLen), .rspFetch(rspFetch),
		.rspCache(rspCache), .rspBe(rspBe), .rspHit(rspHit), .rspLast(rspLast),
		.memRdata(memRdata), .coreRdata(coreRdata));

	mra_core_model i_mra_core_model (
		.clk_sys(clk_sys), .accValid(accValid), .accAddr(accAddr), .accLen(accLen),
		.accFetch(accFetch), .accMmr(accMmr), .accDram(accDram), .accReady(accReady),
		.rspValid(rspValid), .rspAddr(rspAddr), .rspLen(rspLen), .rspHit(rspHit),
		.rspCache(rspCache), .rspBe(rspBe), .rspLast(rspLast), .memRdata(memRdata),
		.coreRdata(coreRdata));

	// ---------------------------------------------
	// compare, report and close
	// ---------------------------------------------
	task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// register write held until taken, then the sync pulse is looked at
	task automatic reg_wr(input logic [2:0] s, input logic [31:0] d, input logic sync);
		int i;
		@(negedge clk_sys);
		regSel   = s;
		regWdata = d;
		regWr    = 1'b1;
		i = 0;
		while (regReady !== 1'b1 && i < 50) begin
			@(negedge clk_sys);
			i++;
		end
		@(negedge clk_sys);
		regWr = 1'b0;
		chk(80'(dcacheSync), 80'(sync));
	endtask

	// register read: answer stands in the cycle after the request
	task automatic reg_rd(input logic [2:0] s, input logic [31:0] exp);
		@(negedge clk_sys);
		regSel = s;
		regRd  = 1'b1;
		@(negedge clk_sys);
		regRd = 1'b0;
		chk(80'({regRvalid, regRdata}), 80'({1'b1, exp}));
	endtask

	// one gathered piece against its expectation; hit code 3 means not compared
	task automatic pc(input int k, input logic [31:0] a, input logic [4:0] n,
			input logic [1:0] h, input logic c, input logic be, input logic last);
		logic [73:0] m;
		logic [73:0] e;
		m = (h === 2'h3) ? ~(74'h3 << 35) : ~74'h0;
		e = {a, n, h, c, be, last, be ? 32'h44332211 : 32'h11223344};
		chk(80'(i_mra_core_model.pieces[k] & m), 80'(e & m));
	endtask

	// word access that stays in one region; fl is {fetch, control reg, data ram}
	task automatic acc1(input logic [31:0] a, input logic [2:0] fl, input logic [1:0] h,
			input logic c, input logic be);
		i_mra_core_model.access(a, 5'd4, fl[2], fl[1], fl[0]);
		chk(80'(i_mra_core_model.pieces.size()), 80'(1));
		pc(0, a, 5'd4, h, c, be, 1'b1);
		chk(80'(rspFetch), 80'(fl[2]));
	endtask

	// ---------------------------------------------
	// watchdog
	// ---------------------------------------------
	initial begin
		#(40 * 3000);
		n_errors++;
		report_and_stop();
	end

	// ---------------------------------------------
	// main sequence
	// ---------------------------------------------
	initial begin
		clk_sys   = 1'b0;
		rst_b     = 1'b0;
		bootImage = 32'h80000000;
		swReinit  = 1'b0;
		regSel    = 3'h0;
		regWr     = 1'b0;
		regRd     = 1'b0;
		regWdata  = 32'h0;
		repeat (5) @(negedge clk_sys);
		rst_b = 1'b1;
		reg_rd(REG_DEFAULT_CFG, 32'h1);
		reg_rd(REG_T0_MASK, 32'h0);
		reg_rd(REG_T0_BASE, 32'h1);
		acc1(32'h00105000, 3'b000, HIT_NONE, 1'b0, 1'b1);
		reg_wr(REG_DEFAULT_CFG, 32'h0, 1'b1);
		reg_wr(REG_T0_BASE, 32'h00100003, 1'b1);
		reg_rd(REG_T0_BASE, 32'h00100002);
		reg_wr(REG_T0_MASK, 32'hffff0001, 1'b1);
		reg_rd(REG_T0_MASK, 32'hffff0001);
		acc1(32'h0010f000, 3'b000, HIT_T0, 1'b1, 1'b0);
		acc1(32'h00205000, 3'b000, HIT_NONE, 1'b0, 1'b0);
		acc1(32'h00105000, 3'b001, 2'h3, 1'b0, 1'b0);
		acc1(32'h00105000, 3'b010, HIT_NONE, 1'b0, 1'b0);
		reg_wr(REG_T0_MASK, 32'hffff0000, 1'b1);
		acc1(32'h00105000, 3'b000, HIT_NONE, 1'b0, 1'b0);
		reg_wr(REG_T1_BASE, 32'h00000000, 1'b1);
		reg_wr(REG_T1_MASK, 32'hff0f0001, 1'b1);
		acc1(32'h00305000, 3'b000, HIT_T1, 1'b0, 1'b0);
		acc1(32'h01305000, 3'b000, HIT_NONE, 1'b0, 1'b0);
		reg_wr(REG_DEFAULT_CFG, 32'h3, 1'b1);
		acc1(32'h01305000, 3'b100, HIT_NONE, 1'b1, 1'b1);
		acc1(32'h00305000, 3'b000, HIT_T1, 1'b0, 1'b1);
		acc1(32'h00305000, 3'b001, 2'h3, 1'b0, 1'b1);
		acc1(32'h00305000, 3'b010, HIT_NONE, 1'b1, 1'b0);
		// access across a template edge, template 0 on one page only
		reg_wr(REG_T1_MASK, 32'h0, 1'b1);
		reg_wr(REG_T0_BASE, 32'h00001000, 1'b1);
		reg_wr(REG_T0_MASK, 32'hfffff001, 1'b1);
		i_mra_core_model.access(32'h00000ffe, 5'd8, 1'b0, 1'b0, 1'b0);
		chk(80'(i_mra_core_model.pieces.size()), 80'(3));
		pc(0, 32'h00000ffe, 5'd2, HIT_NONE, 1'b1, 1'b1, 1'b0);
		pc(1, 32'h00001000, 5'd4, HIT_T0, 1'b0, 1'b1, 1'b0);
		pc(2, 32'h00001004, 5'd2, HIT_T0, 1'b0, 1'b1, 1'b1);
		// odd start fetch across the same edge: one byte, then a halfword
		i_mra_core_model.access(32'h00000fff, 5'd3, 1'b1, 1'b0, 1'b0);
		chk(80'(i_mra_core_model.pieces.size()), 80'(2));
		pc(0, 32'h00000fff, 5'd1, HIT_NONE, 1'b1, 1'b1, 1'b0);
		pc(1, 32'h00001000, 5'd2, HIT_T0, 1'b0, 1'b1, 1'b1);
		chk(80'(rspFetch), 80'(1));
		// unmapped index: no effect and reads as zero
		reg_wr(3'h5, 32'hffffffff, 1'b0);
		reg_rd(3'h5, 32'h0);
		// software re-initialisation
		@(negedge clk_sys);
		swReinit = 1'b1;
		@(negedge clk_sys);
		swReinit = 1'b0;
		reg_rd(REG_DEFAULT_CFG, 32'h1);
		// second hardware reset with little-endian boot image
		@(negedge clk_sys);
		rst_b     = 1'b0;
		bootImage = 32'h7fffffff;
		repeat (2) @(negedge clk_sys);
		rst_b = 1'b1;
		reg_rd(REG_DEFAULT_CFG, 32'h0);
		reg_rd(REG_T0_MASK, 32'h0);
		report_and_stop();
	end
endmodule
